// ---- hdl/cmcd_cfg.svh ----
`ifndef CMCD_CFG_SVH
`define CMCD_CFG_SVH
// register indices on the 4-bit serial address
`define CMCD_ADDR_MAIN_CFG      4'h1
`define CMCD_ADDR_I_OFFSET      4'h2
`define CMCD_ADDR_I_RANGE       4'h3
`define CMCD_ADDR_EXT_CFG       4'h9
`define CMCD_ADDR_Q_OFFSET      4'hA
`define CMCD_ADDR_Q_RANGE       4'hB
`define CMCD_ADDR_PHASE_FINE    4'hE
`define CMCD_ADDR_PHASE_COARSE  4'hF
// main configuration fields
`define CMCD_BIT_SECOND_CLK_DIS 13
`define CMCD_BIT_DDR_PHASE      11
`define CMCD_BIT_DDR_DISABLE    10
`define CMCD_BIT_SWING          9
`define CMCD_BIT_EDGE_DEMUX     8
// extended configuration fields
`define CMCD_BIT_PATTERN        15
`define CMCD_BIT_TRIM_DIS       14
`define CMCD_BIT_DUAL_EDGE      13
`define CMCD_BIT_DES_Q_SEL      12
// 9-bit adjust fields sit in bits 15..7, the 8-bit fine phase field in bits 15..8
`define CMCD_FIELD_HI           15
`define CMCD_FIELD_LO           7
`define CMCD_FINE_LO            8
// reset values
`define CMCD_RST_MAIN_CFG       16'hB2FF
`define CMCD_RST_EXT_CFG        16'h03FF
`define CMCD_RST_MID_SCALE      16'h807F
`define CMCD_RST_PHASE          16'h007F
// serial frame
`define CMCD_FRAME_BITS         6'd32
`define CMCD_HEADER             12'h001
`endif

// ---- hdl/cmcd_pkg.sv ----
package cmcd_pkg;
   // tri-level pin reading after filtering
   typedef enum logic [1:0] {
      CMCD_PIN_LOW   = 2'b00,
      CMCD_PIN_HIGH  = 2'b01,
      CMCD_PIN_FLOAT = 2'b10
   } cmcd_pin_t;

   // decoded active configuration
   typedef struct packed {
      logic       ext_mode;
      logic       double_rate;
      logic       double_rate_clock_phase;
      logic       sdr_rise_edge;
      logic       output_swing_select;
      logic       long_cal_delay;
      logic       dual_edge;
      logic       des_q_input;
      logic       pattern_output_enable;
      logic       clocks_continuous;
      logic       non_demux;
      logic       second_clock;
      logic       range_reduced;
      logic [8:0] i_range;
      logic [8:0] q_range;
      logic [8:0] i_offset;
      logic [8:0] q_offset;
      logic [8:0] phase_coarse_mid;
      logic [7:0] phase_fine;
   } cmcd_cfg_t;

   // one completed serial write
   typedef struct packed {
      logic        valid;
      logic [3:0]  addr;
      logic [15:0] data;
   } cmcd_wr_t;

   typedef enum logic [0:0] {
      CMCD_SER_IDLE  = 1'b0,
      CMCD_SER_SHIFT = 1'b1
   } cmcd_ser_state_t;
endpackage

// ---- hdl/cmcd_pin_filter.sv ----
`timescale 1ns/10ps
`include "cmcd_cfg.svh"
// three-stage sync of a tri-level pin (drive high / drive low / float sense)
module cmcd_pin_filter
   import cmcd_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   input  wire logic [1:0] pin_i,
   output cmcd_pin_t      level_o
);
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;
   cmcd_pin_t  lvl_q;

   // =====================================================
   // synchroniser chain
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         // start at float like lvl_q, so no false low is taken after reset
         s1_q <= 2'h2;
         s2_q <= 2'h2;
         s3_q <= 2'h2;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // accept a change once stages two and three agree
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lvl_q <= CMCD_PIN_FLOAT;
      else if (s2_q == s3_q)
         lvl_q <= cmcd_pin_t'(s3_q == 2'h3 ? 2'h2 : s3_q);
   end

   assign level_o = lvl_q;
endmodule

// ---- hdl/cmcd_reg_mem.sv ----
`timescale 1ns/10ps
`include "cmcd_cfg.svh"
// sixteen-word register store, registered read ports for every word
module cmcd_reg_mem
   import cmcd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  cmcd_wr_t         wr_i,
   output logic [15:0]      word_o [16]
);
   // reset value per address
   function automatic logic [15:0] rst_val(input logic [3:0] a);
      case (a)
         `CMCD_ADDR_MAIN_CFG:     rst_val = `CMCD_RST_MAIN_CFG;
         `CMCD_ADDR_EXT_CFG:      rst_val = `CMCD_RST_EXT_CFG;
         `CMCD_ADDR_I_OFFSET,
         `CMCD_ADDR_Q_OFFSET,
         `CMCD_ADDR_I_RANGE,
         `CMCD_ADDR_Q_RANGE:      rst_val = `CMCD_RST_MID_SCALE;
         `CMCD_ADDR_PHASE_FINE,
         `CMCD_ADDR_PHASE_COARSE: rst_val = `CMCD_RST_PHASE;
         default:                 rst_val = 16'h0000;
      endcase
   endfunction

   genvar g;
   generate
      for (g = 0; g < 16; g++)
      begin : gen_word
         // one word, loaded on a matching completed frame
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               word_o[g] <= rst_val(4'(g));
            else if (wr_i.valid && wr_i.addr == 4'(g))
               word_o[g] <= wr_i.data;
         end
      end
   endgenerate
endmodule

// ---- hdl/cmcd_top.sv ----
`timescale 1ns/10ps
`include "cmcd_cfg.svh"
// What this block does
// - low mode pin forces extended control
// - floating mode pins let range pin enable extended
// - ddr disable bit 10 or pin selects clocking
// - ddr phase bit 11 extended only
// - sdr edge from pin or bit 8
// - lvds swing from pin or bit 9
// - cal delay pin standard, short in extended
// - per-channel 512-step range from 3h, Bh
// - offset only extended, from 2h, Ah
// - dual edge: cal pin float or 9h bit13
// - dual edge q input only in extended
// - test pattern bit 15 of 9h extended
// - trim disable keeps output clocks running
// - ddr extended: edge bit picks demux
// - cleared bit 13 makes second clock
// - phase adjust from Fh and Eh extended
// - internal reset loads extended defaults
// - default ddr, zero phase, high swing, short
// - default 700 mV, no offset, no des, no pattern
// - default trim on, demux, overrange, zero phase
// - 32-bit frame, header, address, data, msb first
// - registers ignored in standard mode
module cmcd_top
   import cmcd_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] mode_sel_pin_i,
   input  wire logic [1:0] mode_aux_pin_i,
   input  wire logic [1:0] range_pin_i,
   input  wire logic [1:0] edge_rate_pin_i,
   input  wire logic [1:0] swing_pin_i,
   input  wire logic [1:0] cal_delay_pin_i,
   input  wire logic       ser_clk_i,
   input  wire logic       ser_data_i,
   input  wire logic       ser_sel_n_i,
   output cmcd_cfg_t       cfg_o
);
   // =====================================================
   // pin filtering
   cmcd_pin_t mode_sel;
   cmcd_pin_t mode_aux;
   cmcd_pin_t range_pin;
   cmcd_pin_t edge_pin;
   cmcd_pin_t swing_pin;
   cmcd_pin_t cal_pin;
   logic [2:0] ser_pins;
   cmcd_pin_t  ser_lvl [3];

   cmcd_pin_filter u_f_mode (.clk_i(clk_i), .rst_i(rst_i), .pin_i(mode_sel_pin_i),
                             .level_o(mode_sel));
   cmcd_pin_filter u_f_aux  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(mode_aux_pin_i),
                             .level_o(mode_aux));
   cmcd_pin_filter u_f_rng  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(range_pin_i),
                             .level_o(range_pin));
   cmcd_pin_filter u_f_edge (.clk_i(clk_i), .rst_i(rst_i), .pin_i(edge_rate_pin_i),
                             .level_o(edge_pin));
   cmcd_pin_filter u_f_swg  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(swing_pin_i),
                             .level_o(swing_pin));
   cmcd_pin_filter u_f_cal  (.clk_i(clk_i), .rst_i(rst_i), .pin_i(cal_delay_pin_i),
                             .level_o(cal_pin));

   // serial pins reuse the filter as two-level inputs
   assign ser_pins = {ser_clk_i, ser_data_i, ser_sel_n_i};
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : gen_ser
         cmcd_pin_filter u_f_ser (.clk_i(clk_i), .rst_i(rst_i),
                                  .pin_i({1'b0, ser_pins[g]}), .level_o(ser_lvl[g]));
      end
   endgenerate

   logic sclk;
   logic sdat;
   logic scs_n;
   assign sclk  = (ser_lvl[2] == CMCD_PIN_HIGH);
   assign sdat  = (ser_lvl[1] == CMCD_PIN_HIGH);
   assign scs_n = (ser_lvl[0] != CMCD_PIN_LOW);

   // =====================================================
   // control mode decode
   logic ext_mode;
   always_comb
   begin
      ext_mode = 1'b0;
      if (mode_sel == CMCD_PIN_LOW)
         ext_mode = 1'b1;
      else if (mode_sel == CMCD_PIN_FLOAT && mode_aux != CMCD_PIN_LOW
               && range_pin == CMCD_PIN_FLOAT)
         ext_mode = 1'b1;
   end
   // mode is assumed static while running

   // =====================================================
   // serial frame receiver
   cmcd_ser_state_t st_q;
   logic [5:0]      cnt_q;
   logic [31:0]     sh_q;
   logic            sclk_q;
   cmcd_wr_t        wr_q;
   logic            rise;
   logic [31:0]     sh_next;

   assign rise    = sclk && !sclk_q;
   assign sh_next = {sh_q[30:0], sdat};

   // edge detect on the filtered serial clock
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sclk_q <= 1'b0;
      else
         sclk_q <= sclk;
   end

   // bit counting; a frame ends on the 32nd rising edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i || scs_n || !ext_mode)
      begin
         st_q  <= CMCD_SER_IDLE;
         cnt_q <= 6'h00;
      end
      else
      begin
         case (st_q)
            CMCD_SER_IDLE:
            begin
               st_q  <= CMCD_SER_SHIFT;
               cnt_q <= 6'h00;
            end
            CMCD_SER_SHIFT:
            begin
               if (rise)
                  cnt_q <= (cnt_q == `CMCD_FRAME_BITS - 6'd1) ? 6'h00 : cnt_q + 6'd1;
            end
            default:
               st_q <= CMCD_SER_IDLE;
         endcase
      end
   end

   // shift msb first
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sh_q <= 32'h0000_0000;
      else if (rise)
         sh_q <= sh_next;
   end

   // completed frame with valid header becomes a write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wr_q <= '0;
      else
      begin
         wr_q.valid <= st_q == CMCD_SER_SHIFT && !scs_n && ext_mode && rise
                       && cnt_q == `CMCD_FRAME_BITS - 6'd1
                       && sh_next[31:20] == `CMCD_HEADER;
         wr_q.addr  <= sh_next[19:16];
         wr_q.data  <= sh_next[15:0];
      end
   end

   // =====================================================
   // register store, reset to extended defaults
   logic [15:0] word [16];
   cmcd_reg_mem u_mem (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_q), .word_o(word));

   logic [15:0] mcfg;
   logic [15:0] xcfg;
   assign mcfg = word[`CMCD_ADDR_MAIN_CFG];
   assign xcfg = word[`CMCD_ADDR_EXT_CFG];

   // =====================================================
   // active configuration, registers only matter in extended
   cmcd_cfg_t cfg_d;
   cmcd_cfg_t cfg_q;

   always_comb
   begin
      cfg_d = '0;
      cfg_d.ext_mode = ext_mode;
      if (ext_mode)
      begin
         cfg_d.double_rate             = !mcfg[`CMCD_BIT_DDR_DISABLE];
         cfg_d.double_rate_clock_phase = mcfg[`CMCD_BIT_DDR_PHASE];
         cfg_d.sdr_rise_edge           = mcfg[`CMCD_BIT_EDGE_DEMUX];
         cfg_d.output_swing_select     = mcfg[`CMCD_BIT_SWING];
         cfg_d.long_cal_delay          = 1'b0;
         cfg_d.dual_edge               = xcfg[`CMCD_BIT_DUAL_EDGE];
         cfg_d.des_q_input             = xcfg[`CMCD_BIT_DES_Q_SEL];
         cfg_d.pattern_output_enable   = xcfg[`CMCD_BIT_PATTERN];
         cfg_d.clocks_continuous       = xcfg[`CMCD_BIT_TRIM_DIS];
         cfg_d.non_demux               = !mcfg[`CMCD_BIT_DDR_DISABLE]
                                         && mcfg[`CMCD_BIT_EDGE_DEMUX];
         cfg_d.second_clock            = !mcfg[`CMCD_BIT_SECOND_CLK_DIS];
         cfg_d.i_range  = word[`CMCD_ADDR_I_RANGE][`CMCD_FIELD_HI:`CMCD_FIELD_LO];
         cfg_d.q_range  = word[`CMCD_ADDR_Q_RANGE][`CMCD_FIELD_HI:`CMCD_FIELD_LO];
         cfg_d.i_offset = word[`CMCD_ADDR_I_OFFSET][`CMCD_FIELD_HI:`CMCD_FIELD_LO];
         cfg_d.q_offset = word[`CMCD_ADDR_Q_OFFSET][`CMCD_FIELD_HI:`CMCD_FIELD_LO];
         cfg_d.phase_coarse_mid =
            word[`CMCD_ADDR_PHASE_COARSE][`CMCD_FIELD_HI:`CMCD_FIELD_LO];
         cfg_d.phase_fine = word[`CMCD_ADDR_PHASE_FINE][`CMCD_FIELD_HI:`CMCD_FINE_LO];
      end
      else
      begin
         // edge pin floating selects double rate, else sdr edge follows it
         cfg_d.double_rate         = (edge_pin == CMCD_PIN_FLOAT);
         cfg_d.double_rate_clock_phase = 1'b0;
         cfg_d.sdr_rise_edge       = (edge_pin == CMCD_PIN_HIGH);
         cfg_d.output_swing_select = (swing_pin != CMCD_PIN_LOW);
         cfg_d.long_cal_delay      = (cal_pin == CMCD_PIN_HIGH);
         cfg_d.dual_edge           = (cal_pin == CMCD_PIN_FLOAT);
         cfg_d.des_q_input         = 1'b0;
         cfg_d.range_reduced       = (range_pin == CMCD_PIN_LOW);
         cfg_d.i_range  = 9'h100;
         cfg_d.q_range  = 9'h100;
         cfg_d.i_offset = 9'h100;
         cfg_d.q_offset = 9'h100;
         cfg_d.phase_coarse_mid = 9'h000;
         cfg_d.phase_fine       = 8'h00;
      end
   end

   // registered output
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cfg_q <= '0;
      else
         cfg_q <= cfg_d;
   end

   assign cfg_o = cfg_q;
endmodule

// ---- dv/cmcd_monitor.sv ----
`timescale 1ns/10ps
// ==========================================================
// decode checker on the top ports
module cmcd_monitor
   import cmcd_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] mode_sel_pin_i,
   input  wire logic [1:0] mode_aux_pin_i,
   input  wire logic [1:0] range_pin_i,
   input  cmcd_cfg_t       cfg_o
);
   logic [3:0] age_q;
   logic       ok;
   logic       std_ok;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // saturating age since reset, lets the pin filters settle first
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         age_q <= 4'h0;
      else if (age_q != 4'hF)
         age_q <= age_q + 4'h1;
   end

   // settled standard-mode qualifier
   assign ok     = (age_q > 4'h7);
   assign std_ok = ok && !cfg_o.ext_mode;

   por_zero_a: assert property (
      $past(rst_i) |-> cfg_o == '0) else $error("config not cleared by reset");
   low_sel_ext_a: assert property (
      (mode_sel_pin_i == 2'h0) [*8] |=> cfg_o.ext_mode) else $error("low select not extended");
   high_sel_std_a: assert property (
      (mode_sel_pin_i == 2'h1) [*8] |=> !cfg_o.ext_mode) else $error("high select not standard");
   float_range_ext_a: assert property (
      (mode_sel_pin_i[1] && mode_aux_pin_i != 2'h0 && range_pin_i[1]) [*8] |=> cfg_o.ext_mode)
      else $error("floating range pin did not enable extended");
   std_phase_a: assert property (
      std_ok |-> !cfg_o.double_rate_clock_phase) else $error("phase set in standard");
   ext_cal_a: assert property (
      ok && cfg_o.ext_mode |-> !cfg_o.long_cal_delay) else $error("long delay in extended");
   std_offset_a: assert property (
      std_ok |-> cfg_o.i_offset == 9'h100 && cfg_o.q_offset == 9'h100)
      else $error("offset adjusted in standard");
   std_pattern_a: assert property (
      std_ok |-> !cfg_o.pattern_output_enable) else $error("pattern in standard");
   std_clocks_a: assert property (
      std_ok |-> !cfg_o.clocks_continuous && !cfg_o.second_clock)
      else $error("clock option in standard");
   std_q_input_a: assert property (
      std_ok |-> !cfg_o.des_q_input) else $error("q input chosen in standard");
endmodule

// ---- dv/cmcd_host.sv ----
`timescale 1ns/10ps
// ==========================================================
// host model: serial register writer
module cmcd_host
(
   input  wire logic clk_i,
   output logic      ser_clk_o,
   output logic      ser_data_o,
   output logic      ser_sel_n_o
);
   // idle: clock parked low, select released
   initial
   begin
      ser_clk_o   = 1'b0;
      ser_data_o  = 1'b1;
      ser_sel_n_o = 1'b1;
   end

   // one frame: header, address, data, msb first, five clk per half bit
   task automatic send(input logic [11:0] hdr, input logic [3:0] adr, input logic [15:0] dat);
      logic [31:0] frm;
      frm = {hdr, adr, dat};
      @(negedge clk_i);
      ser_sel_n_o = 1'b0;
      for (int i = 31; i >= 0; i--)
      begin
         ser_data_o = frm[i];
         repeat (5) @(negedge clk_i);
         ser_clk_o = 1'b1;
         repeat (5) @(negedge clk_i);
         ser_clk_o = 1'b0;
      end
      ser_sel_n_o = 1'b1;
      ser_data_o  = ~ser_data_o; // released line must not keep the last bit
   endtask
endmodule

// ---- dv/control_mode_config_decode_tb.sv ----
`timescale 1ns/10ps
// ==========================================================
// bench top
module control_mode_config_decode_tb
   import cmcd_pkg::*;
;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [1:0] msel  = 2'h0;
   logic [1:0] maux  = 2'h2;
   logic [1:0] rng   = 2'h2;
   logic [1:0] edg   = 2'h2;
   logic [1:0] swg   = 2'h2;
   logic [1:0] cal   = 2'h2;
   logic       ser_clk;
   logic       ser_data;
   logic       ser_sel_n;
   cmcd_cfg_t  cfg;
   cmcd_cfg_t  exp_c;
   cmcd_cfg_t  msk;
   int         mismatches = 0;
   int         tests_run = 0;

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   cmcd_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .mode_sel_pin_i(msel), .mode_aux_pin_i(maux),
      .range_pin_i(rng), .edge_rate_pin_i(edg), .swing_pin_i(swg), .cal_delay_pin_i(cal),
      .ser_clk_i(ser_clk), .ser_data_i(ser_data), .ser_sel_n_i(ser_sel_n), .cfg_o(cfg));
   cmcd_host i_host (.clk_i(clk_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
      .ser_sel_n_o(ser_sel_n));

   // ==========================================================
   // tasks
   task conclude;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // masked compare of the decoded configuration
   task chk(input string what);
      tests_run++;
      if ((cfg & msk) !== (exp_c & msk))
      begin
         mismatches++;
         $display("Error at %0t: %s got %h expected %h", $time, what, cfg, exp_c);
      end
   endtask

   // mode pins change only under reset, so the mode never moves while running
   task boot(input logic [1:0] m, a, r, e, s, c);
      @(negedge clk_i);
      rst_i = 1'b1;
      {msel, maux, rng, edg, swg, cal} = {m, a, r, e, s, c};
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (20) @(negedge clk_i);
      msk   = '1;
      exp_c = '0;
   endtask

   task wr(input logic [3:0] a, input logic [15:0] d, input logic [11:0] h = 12'h001);
      i_host.send(h, a, d);
      repeat (12) @(negedge clk_i);
   endtask

   // ==========================================================
   // watchdog
   initial
   begin
      repeat (30000) @(posedge clk_i);
      mismatches++;
      $display("Error at %0t: watchdog expired", $time);
      conclude();
   end

   // ==========================================================
   // tests
   initial
   begin
      boot(2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2);
      msk.sdr_rise_edge = 1'b0;
      msk.range_reduced = 1'b0;
      exp_c.ext_mode = 1'b1;
      exp_c.double_rate = 1'b1;
      exp_c.output_swing_select = 1'b1;
      {exp_c.i_range, exp_c.q_range, exp_c.i_offset, exp_c.q_offset} = {4{9'h100}};
      chk("ext defaults");
      $display("test ext_defaults done");
      wr(4'h1, 16'h99FF);
      exp_c.second_clock = 1'b1;
      exp_c.double_rate_clock_phase = 1'b1;
      exp_c.output_swing_select = 1'b0;
      exp_c.non_demux = 1'b1;
      chk("main cfg");
      wr(4'h9, 16'hF3FF);
      exp_c.pattern_output_enable = 1'b1;
      exp_c.clocks_continuous = 1'b1;
      exp_c.dual_edge = 1'b1;
      exp_c.des_q_input = 1'b1;
      chk("ext cfg");
      wr(4'h3, 16'hFFFF);
      wr(4'hB, 16'h0000);
      wr(4'h2, 16'h0080);
      wr(4'hA, 16'h7F80);
      wr(4'hF, 16'hFF80);
      wr(4'hE, 16'hAB00);
      {exp_c.i_range, exp_c.q_range, exp_c.i_offset} = {9'h1FF, 9'h000, 9'h001};
      {exp_c.q_offset, exp_c.phase_coarse_mid, exp_c.phase_fine} = {9'h0FF, 9'h1FF, 8'hAB};
      chk("adjust words");
      wr(4'h1, 16'hB2FF, 12'h003);
      wr(4'h4, 16'h0000);
      chk("bad header and reserved");
      wr(4'h1, 16'hB7FF);
      exp_c.double_rate = 1'b0;
      exp_c.double_rate_clock_phase = 1'b0;
      exp_c.output_swing_select = 1'b1;
      exp_c.second_clock = 1'b0;
      exp_c.sdr_rise_edge = 1'b1;
      msk.sdr_rise_edge = 1'b1;
      exp_c.non_demux = 1'b0;
      chk("sdr ext");
      $display("test ext_writes done");
      boot(2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1);
      exp_c.sdr_rise_edge = 1'b1;
      exp_c.long_cal_delay = 1'b1;
      exp_c.range_reduced = 1'b1;
      {exp_c.i_range, exp_c.q_range, exp_c.i_offset, exp_c.q_offset} = {4{9'h100}};
      chk("std pins");
      wr(4'h1, 16'h9BFF);
      wr(4'h9, 16'hF3FF);
      chk("std ignores serial");
      edg = 2'h2;
      swg = 2'h1;
      cal = 2'h2;
      repeat (20) @(negedge clk_i);
      exp_c.double_rate = 1'b1;
      exp_c.dual_edge = 1'b1;
      exp_c.output_swing_select = 1'b1;
      msk.sdr_rise_edge = 1'b0;
      msk.long_cal_delay = 1'b0;
      chk("std ddr and dual edge");
      $display("test standard done");
      boot(2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2);
      msk = '0;
      msk.ext_mode = 1'b1;
      exp_c.ext_mode = 1'b1;
      chk("float range ext");
      boot(2'h2, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2);
      msk = '0;
      msk.ext_mode = 1'b1;
      chk("aux low std");
      boot(2'h2, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2);
      msk = '0;
      msk.ext_mode = 1'b1;
      chk("range high std");
      $display("test mode_select done");
      conclude();
   end
endmodule

bind cmcd_top cmcd_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
   .mode_sel_pin_i(mode_sel_pin_i), .mode_aux_pin_i(mode_aux_pin_i),
   .range_pin_i(range_pin_i), .cfg_o(cfg_o));
